// >>> rtl/adc_ctrl.v
// Converter control: register file, bus slave, interrupt, analog steering
//
// Operation
// - System reset restores every register and leaves the converter powered down.
// - Reset during a conversion abandons it, clearing done flag and approximation bits.
// - System reset cancels any pending converter interrupt request.
// - Setting the power-up bit does not reinitialise any register.
// - Writing the main control register stops a conversion without starting another.
// - With interrupt enabled, conversion end raises request with result already stored.
// - Interrupt request is asserted while done flag and enable are both set, or while any status bit enabled by the mask is set.
// - Any write to the status and control register clears the done flag.
// - Reading either result register clears the done flag.
// - Multiplexer routes exactly one of eight channels, chosen by channel select.
// - Writing status and control while powered up starts a conversion, aborting any running one.
// - Sampling lasts fourteen conversion clock periods before approximation begins.
// - A disabled pin converts the low reference, giving zero results.
// - Writing the pin enable register aborts a conversion without starting one.
`default_nettype none
`include "adc_ctrl_defines.vh"

module adc_ctrl #(
	parameter RES_W = 10,
	parameter PRS_W = 4
) (
	// Clock and reset
	input  wire        hclk,
	input  wire        hresetn,
	// AHB-Lite slave
	input  wire        hsel,
	input  wire [7:0]  haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg         hreadyout,
	output reg         hresp,
	output reg  [31:0] hrdata,
	// Analog front end
	input  wire        comp_in,
	output reg  [2:0]  channel_sel,
	output reg         ref_low_sel,
	output reg         sample_en,
	output reg         powered,
	output reg  [RES_W-1:0] dac_code,
	// Interrupt
	output reg         irq
);

	// Register file
	reg [7:0]       ctrl_reg;
	reg             irq_en_reg;
	reg [2:0]       chan_reg;
	reg             done_flag_reg;
	reg [7:0]       pin_en_reg;
	reg [RES_W-1:0] res_reg;
	reg             res_lj_reg;
	reg             res_8b_reg;
	reg [1:0]       ist_reg;
	reg [1:0]       mask_reg;

	// Bus pipeline
	reg             wr_pend_reg;
	reg             rd_pend_reg;
	reg [7:0]       addr_reg;

	// Engine links
	wire             tick;
	wire             eng_sampling;
	wire             eng_busy;
	wire [RES_W-1:0] eng_code;
	wire             eng_done;
	wire [RES_W-1:0] eng_result;

	// Next values for flags
	reg             done_flag_next;
	reg [1:0]       ist_next;
	reg             start_conv;
	reg             abort_conv;

	// Reset image of the status and control register
	localparam [7:0] SC_RST_V = `SC_RST;

	// Formats one result byte from the stored code
	function [7:0] fmt_result;
		input [RES_W-1:0] code;
		input             lj;
		input             eight;
		input             high;
		reg   [15:0]      word;
		begin
			word = 16'h0000;
			if (eight)
				word = {code[RES_W-1:RES_W-8], 8'h00};
			else if (lj)
				word = {code, 6'h00};
			else
				word = {6'h00, code};
			fmt_result = high ? word[15:8] : word[7:0];
		end
	endfunction

	// Address phase accepted by this slave
	wire bus_take = hsel && htrans[1] && hready;
	wire pu       = ctrl_reg[`CTRL_PU_BIT];
	wire rd_fire  = rd_pend_reg;
	wire wr_fire  = wr_pend_reg;

	wire wr_ctrl  = wr_fire && (addr_reg == `OFF_CTRL);
	wire wr_sc    = wr_fire && (addr_reg == `OFF_STAT_CTRL);
	wire wr_pe    = wr_fire && (addr_reg == `OFF_PIN_EN);
	wire wr_mask  = wr_fire && (addr_reg == `OFF_IRQ_MASK);
	wire rd_res   = rd_fire && ((addr_reg == `OFF_RES_HIGH) ||
	                            (addr_reg == `OFF_RES_LOW));
	wire rd_ist   = rd_fire && (addr_reg == `OFF_IRQ_STATUS);

	// Channel carried by a status write; the stored field lags one cycle
	wire [2:0] new_chan = hwdata[`SC_CH_MSB:`SC_CH_LSB];

	// Restarting the prescaler with each conversion keeps the sample
	// window at whole conversion clock periods, whatever the tick phase
	wire clk_run  = pu && !start_conv;

	// Prescaled conversion clock, stopped while powered down
	conv_clock_gen #(
		.PRS_W    (PRS_W)
	) u_clk (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.run      (clk_run),
		.prescale (ctrl_reg[`CTRL_PRS_MSB:`CTRL_PRS_LSB]),
		.tick     (tick)
	);

	// Sampling and approximation sequencer
	sar_engine #(
		.RES_W      (RES_W)
	) u_sar (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.tick       (tick),
		.start      (start_conv),
		.abort      (abort_conv),
		.eight_bit  (ctrl_reg[`CTRL_8B_BIT]),
		.zero_input (~pin_en_reg[new_chan]),
		.comp_in    (comp_in),
		.sampling   (eng_sampling),
		.busy       (eng_busy),
		.sar_code   (eng_code),
		.done       (eng_done),
		.result     (eng_result)
	);

	// Start and abort decisions from data-phase writes
	always @*
	begin
		start_conv = wr_sc && pu;
		// pin enable write stops
		// A status write also aborts; the engine lets the start win
		abort_conv = wr_ctrl || wr_pe || wr_sc ||
			(!pu && eng_busy);
	end

	// Done flag and sticky events; a completion beats a same-cycle clear
	always @*
	begin
		done_flag_next = done_flag_reg;
		ist_next       = ist_reg;
		if (wr_sc)
			done_flag_next = 1'b0;
		if (rd_res)
			done_flag_next = 1'b0;
		if (rd_ist)
			ist_next = `IST_RST;
		if (eng_done)
		begin
			done_flag_next           = 1'b1;
			ist_next[`IST_DONE_BIT]  = 1'b1;
		end
		if (abort_conv && eng_busy)
			ist_next[`IST_ABORT_BIT] = 1'b1;
	end

	// Bus pipeline; reads take one wait state so hrdata comes from a flop
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			addr_reg    <= 8'h00;
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
		end
		else
		begin
			wr_pend_reg <= bus_take && hwrite;
			rd_pend_reg <= bus_take && !hwrite;
			if (bus_take)
				addr_reg <= haddr;
			hreadyout   <= !(bus_take && !hwrite);
			hresp       <= 1'b0;
		end
	end

	// Read data, formed while the master waits
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h0000_0000;
		else if (rd_fire)
		begin
			case (addr_reg)
			`OFF_CTRL:
				hrdata <= {24'h0, ctrl_reg};
			`OFF_STAT_CTRL:
				hrdata <= {24'h0, done_flag_reg, irq_en_reg, 3'b000,
					chan_reg};
			`OFF_RES_HIGH:
				hrdata <= {24'h0, fmt_result(res_reg, res_lj_reg,
					res_8b_reg, 1'b1)};
			`OFF_RES_LOW:
				hrdata <= {24'h0, fmt_result(res_reg, res_lj_reg,
					res_8b_reg, 1'b0)};
			`OFF_PIN_EN:
				hrdata <= {24'h0, pin_en_reg};
			`OFF_IRQ_STATUS:
				hrdata <= {30'h0, ist_reg};
			`OFF_IRQ_MASK:
				hrdata <= {30'h0, mask_reg};
			default:
				hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// Software-written registers
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctrl_reg   <= `CTRL_RST;
			// Enable and channel take their slices of the reset image
			irq_en_reg <= SC_RST_V[`SC_IE_BIT];
			chan_reg   <= SC_RST_V[`SC_CH_MSB:`SC_CH_LSB];
			pin_en_reg <= `PE_RST;
			mask_reg   <= `MASK_RST;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_reg <= hwdata[7:0];
			if (wr_sc)
			begin
				irq_en_reg <= hwdata[`SC_IE_BIT];
				chan_reg   <= hwdata[`SC_CH_MSB:`SC_CH_LSB];
			end
			if (wr_pe)
				pin_en_reg <= hwdata[7:0];
			if (wr_mask)
				mask_reg <= hwdata[1:0];
		end
	end

	// Result and flags
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			done_flag_reg <= 1'b0;
			res_reg       <= {RES_W{1'b0}};
			res_lj_reg    <= 1'b0;
			res_8b_reg    <= 1'b0;
			ist_reg       <= `IST_RST;
		end
		else
		begin
			done_flag_reg <= done_flag_next;
			ist_reg       <= ist_next;
			if (eng_done)
			begin
				res_reg    <= eng_result;
				res_lj_reg <= ctrl_reg[`CTRL_LJ_BIT];
				res_8b_reg <= ctrl_reg[`CTRL_8B_BIT];
			end
		end
	end

	// Interrupt output tracks the next flag state, so it rises with the flag
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			irq <= 1'b0;
		else
			irq <= (done_flag_next && irq_en_reg) ||
				(|(ist_next & mask_reg));
	end

	// Analog steering; channel held steady for the whole conversion
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			channel_sel <= 3'h0;
			ref_low_sel <= 1'b0;
			sample_en   <= 1'b0;
			powered     <= 1'b0;
			dac_code    <= {RES_W{1'b0}};
		end
		else
		begin
			if (start_conv)
			begin
				channel_sel <= new_chan;
				ref_low_sel <= ~pin_en_reg[new_chan];
			end
			sample_en <= eng_sampling;
			powered   <= pu;
			dac_code  <= eng_code;
		end
	end

endmodule

`default_nettype wire

// >>> rtl/adc_ctrl_defines.vh
// Register map, field positions, reset values and timing counts
`ifndef ADC_CTRL_DEFINES_VH
`define ADC_CTRL_DEFINES_VH

// Word offsets on the register bus
`define OFF_CTRL        8'h00
`define OFF_STAT_CTRL   8'h04
`define OFF_RES_HIGH    8'h08
`define OFF_RES_LOW     8'h0c
`define OFF_PIN_EN      8'h10
`define OFF_IRQ_STATUS  8'h14
`define OFF_IRQ_MASK    8'h18

// Control register fields
`define CTRL_PU_BIT     7
`define CTRL_LJ_BIT     6
`define CTRL_8B_BIT     5
`define CTRL_PRS_LSB    0
`define CTRL_PRS_MSB    3
`define CTRL_RST        8'h00

// Status and control register fields
`define SC_CCF_BIT      7
`define SC_IE_BIT       6
`define SC_CH_LSB       0
`define SC_CH_MSB       2
`define SC_RST          8'h00

// Pin enable and interrupt register resets
`define PE_RST          8'h00
`define IST_DONE_BIT    0
`define IST_ABORT_BIT   1
`define IST_RST         2'h0
`define MASK_RST        2'h0

// Sample window in conversion clock periods
`define SAMPLE_TICKS    14

`endif

// >>> rtl/conv_clock_gen.v
// Prescaler making the conversion clock as a one-cycle tick
`default_nettype none

module conv_clock_gen #(
	parameter PRS_W = 4
) (
	// Clock and reset
	input  wire             hclk,
	input  wire             hresetn,
	// Control
	input  wire             run,
	input  wire [PRS_W-1:0] prescale,
	// Tick out
	output reg              tick
);

	reg [PRS_W:0] cnt_reg;

	// Tick every 2*(prescale+1) bus cycles; parked one count in while
	// stopped, so the first tick after a restart is a full period later
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cnt_reg <= {(PRS_W+1){1'b0}};
			tick    <= 1'b0;
		end
		else if (!run)
		begin
			cnt_reg <= {{PRS_W{1'b0}}, 1'b1};
			tick    <= 1'b0;
		end
		else if (cnt_reg == {prescale, 1'b1})
		begin
			cnt_reg <= {(PRS_W+1){1'b0}};
			tick    <= 1'b1;
		end
		else
		begin
			cnt_reg <= cnt_reg + 1'b1;
			tick    <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// >>> rtl/sar_engine.v
// Sample window and successive approximation sequencer
`default_nettype none
`include "adc_ctrl_defines.vh"

module sar_engine #(
	parameter RES_W = 10
) (
	// Clock and reset
	input  wire             hclk,
	input  wire             hresetn,
	// Control
	input  wire             tick,
	input  wire             start,
	input  wire             abort,
	input  wire             eight_bit,
	input  wire             zero_input,
	input  wire             comp_in,
	// Status and data
	output reg              sampling,
	output reg              busy,
	output reg  [RES_W-1:0] sar_code,
	output reg              done,
	output reg  [RES_W-1:0] result
);

	localparam ST_IDLE = 2'd0;
	localparam ST_SAMP = 2'd1;
	localparam ST_CONV = 2'd2;
	// Wide images so the counters take a deliberate slice
	localparam [31:0] TOP_BIT_W   = RES_W - 1;
	localparam [31:0] SAMP_LAST_W = `SAMPLE_TICKS - 1;

	reg [1:0] state_reg;
	reg [3:0] cnt_reg;
	reg [3:0] bit_reg;
	reg       zero_reg;
	reg       last_reg;
	reg [RES_W-1:0] trial;

	// Comparator high keeps the trial bit; low reference always drops it
	always @*
	begin
		trial = sar_code;
		if (zero_reg || !comp_in)
			trial[bit_reg] = 1'b0;
	end

	// Sequencer; a start in the abort cycle restarts cleanly
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_reg <= ST_IDLE;
			cnt_reg   <= 4'h0;
			bit_reg   <= 4'h0;
			zero_reg  <= 1'b0;
			last_reg  <= 1'b0;
			sampling  <= 1'b0;
			busy      <= 1'b0;
			sar_code  <= {RES_W{1'b0}};
			done      <= 1'b0;
			result    <= {RES_W{1'b0}};
		end
		else
		begin
			done <= 1'b0;
			if (start)
			begin
				state_reg <= ST_SAMP;
				cnt_reg   <= 4'h0;
				zero_reg  <= zero_input;
				last_reg  <= eight_bit;
				sampling  <= 1'b1;
				busy      <= 1'b1;
				sar_code  <= {RES_W{1'b0}};
			end
			else if (abort)
			begin
				state_reg <= ST_IDLE;
				sampling  <= 1'b0;
				busy      <= 1'b0;
				sar_code  <= {RES_W{1'b0}};
			end
			else if (tick)
			begin
				case (state_reg)
				ST_SAMP:
				begin
					if (cnt_reg == SAMP_LAST_W[3:0])
					begin
						state_reg <= ST_CONV;
						sampling  <= 1'b0;
						bit_reg   <= TOP_BIT_W[3:0];
						sar_code  <= {1'b1, {(RES_W-1){1'b0}}};
					end
					else
						cnt_reg <= cnt_reg + 4'h1;
				end
				ST_CONV:
				begin
					if (bit_reg == (last_reg ? 4'h2 : 4'h0))
					begin
						state_reg <= ST_IDLE;
						busy      <= 1'b0;
						done      <= 1'b1;
						result    <= trial;
						sar_code  <= {RES_W{1'b0}};
					end
					else
					begin
						sar_code <= trial | ({{(RES_W-1){1'b0}}, 1'b1}
							<< (bit_reg - 4'h1));
						bit_reg  <= bit_reg - 4'h1;
					end
				end
				default:
					state_reg <= ST_IDLE;
				endcase
			end
		end
	end

endmodule

`default_nettype wire

// >>> sim/adc_src_model.sv
// Analog sources and comparator behind the input multiplexer
`default_nettype none

module adc_src_model (
	// Steering from the converter
	input  wire logic [2:0] channel_sel,
	input  wire logic       ref_low_sel,
	input  wire logic [9:0] dac_code,
	// Comparator decision
	output var  logic       comp_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [9:0] vin;

	// Each pin sits at a distinct level; low reference reads as zero
	always_comb
	begin
		vin = ref_low_sel ? 10'h000 : {channel_sel, 7'h25};
		comp_in = (vin >= dac_code);
	end
endmodule

`default_nettype wire

// >>> sim/adc_ctrl_asserts.sv
// Port-level checks for the converter control block
`default_nettype none

module adc_ctrl_chk #(
	parameter RES_W = 10
) (
	// Clock and reset
	input wire logic             hclk,
	input wire logic             hresetn,
	// Bus
	input wire logic             hsel,
	input wire logic [7:0]       haddr,
	input wire logic [1:0]       htrans,
	input wire logic             hwrite,
	input wire logic             hready,
	input wire logic             hreadyout,
	input wire logic             hresp,
	input wire logic [31:0]      hrdata,
	// Analog side and interrupt
	input wire logic [2:0]       channel_sel,
	input wire logic             sample_en,
	input wire logic             powered,
	input wire logic [RES_W-1:0] dac_code,
	input wire logic             irq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [9:0] samp_cnt;
	wire        take;
	wire        sc_wr;

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// Transfer accepted at this edge
	assign take = hsel && htrans[1] && hready;
	// Status and control write, which may legally restart on a new channel
	assign sc_wr = take && hwrite && (haddr == 8'h04);

	// Length of the current sample window, for the bound below
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			samp_cnt <= 10'h000;
		else
			samp_cnt <= sample_en ? samp_cnt + 10'h001 : 10'h000;
	end

	a_resp_okay: assert property (hresp == 1'b0)
		else $error("error response seen");
	a_write_no_wait: assert property (take && hwrite |=> hreadyout)
		else $error("write stalled");
	a_read_one_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait not one cycle");
	a_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
		else $error("read data moved");
	a_reset_quiet: assert property ($rose(hresetn) |-> !irq && !powered
		&& !sample_en && dac_code == '0)
		else $error("outputs not cleared by reset");
	a_unpowered_idle: assert property (!powered [*3] |-> !sample_en)
		else $error("sampling while powered down");
	a_chan_hold: assert property (sample_en && $past(sample_en)
		&& !$past(sc_wr, 2) |-> $stable(channel_sel))
		else $error("channel moved in sample window");
	a_pu_no_start: assert property ($rose(powered) |-> !sample_en [*2])
		else $error("power-up started a conversion");
	a_samp_bound: assert property (samp_cnt <= 10'd448)
		else $error("sample window too long");

	c_read: cover property (take && !hwrite);
	c_sample_end: cover property ($fell(sample_en));
	c_irq: cover property ($rose(irq));
endmodule

bind adc_ctrl adc_ctrl_chk #(.RES_W(RES_W)) chk_u (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.channel_sel(channel_sel), .sample_en(sample_en), .powered(powered),
	.dac_code(dac_code), .irq(irq));

`default_nettype wire

// >>> sim/adc_ctrl_bench.sv
// Self-checking bench for the converter control block
`default_nettype none

module adc_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        hclk, hresetn, hsel, hwrite;
	logic [7:0]  haddr;
	logic [1:0]  htrans;
	logic [2:0]  hsize, c;
	logic [31:0] hwdata, rd;
	wire logic        hreadyout, hresp, comp_in, ref_low_sel;
	wire logic        sample_en, powered, irq;
	wire logic [31:0] hrdata;
	wire logic [2:0]  channel_sel;
	wire logic [9:0]  dac_code;
	int bad_count, n_tests, cyc, i, n;

	adc_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .comp_in(comp_in),
		.channel_sel(channel_sel), .ref_low_sel(ref_low_sel),
		.sample_en(sample_en), .powered(powered), .dac_code(dac_code),
		.irq(irq));
	adc_src_model src_u (.channel_sel(channel_sel),
		.ref_low_sel(ref_low_sel), .dac_code(dac_code), .comp_in(comp_in));

	// Verdict and end of run
	task summarize;
		$display("mismatches %0d of %0d checks", bad_count, n_tests);
		if (bad_count == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			bad_count++;
			$display("unexpected %s exp %h seen %h", nm, e, g);
		end
	endtask

	// One single AHB-Lite transfer; read data lands in rd
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask

	task do_reset;
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
	endtask

	// Counts cycles of one whole sample window
	task wait_samp;
		n = 0;
		while (sample_en !== 1'b1) @(posedge hclk);
		while (sample_en === 1'b1)
		begin
			@(posedge hclk);
			n++;
		end
	endtask

	task wait_irq;
		while (irq !== 1'b1) @(posedge hclk);
	endtask

	// Start, time the window, poll, check both result halves
	task conv(input logic [2:0] ch, input logic [9:0] e);
		xfer(1'b1, 8'h04, {29'h0, ch});
		wait_samp;
		chk("sample cycles", 32'd28, n);
		do xfer(1'b0, 8'h04, 32'h0); while (rd[7] !== 1'b1);
		chk("channel", {29'h0, ch}, {29'h0, channel_sel});
		rchk("result high", 8'h08, {30'h0, e[9:8]});
		rchk("result low", 8'h0c, {24'h0, e[7:0]});
		rchk("flag after read", 8'h04, {29'h0, ch});
	endtask

	// Clock and hang guard; long enough for a few hundred conversions
	initial
	begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end
	always @(posedge hclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			bad_count++;
			summarize;
		end
	end

	initial
	begin
		{hresetn, hsel, hwrite, haddr, htrans, hwdata} = '0;
		hsize = 3'h2;
		do_reset;
		for (i = 0; i < 8; i++)
			rchk("reset value", 8'(i * 4), 32'h0);
		xfer(1'b1, 8'h10, 32'hff);
		xfer(1'b1, 8'h00, 32'h80);
		rchk("pin enable kept", 8'h10, 32'hff);
		for (i = 0; i < 8; i++)
		begin
			c = i[2:0];
			conv(c, {c, 7'h25});
		end
		// Enabled interrupt finds the result already stored
		xfer(1'b1, 8'h04, 32'h43);
		wait_irq;
		rchk("result at irq", 8'h0c, 32'ha5);
		repeat (2) @(posedge hclk);
		chk("irq after result read", 32'h0, {31'h0, irq});
		xfer(1'b1, 8'h04, 32'h42);
		wait_irq;
		xfer(1'b1, 8'h04, 32'h00);
		repeat (2) @(posedge hclk);
		chk("irq after status write", 32'h0, {31'h0, irq});
		xfer(1'b1, 8'h04, 32'h05);
		do xfer(1'b0, 8'h04, 32'h0); while (rd[7] !== 1'b1);
		rchk("restarted result", 8'h08, 32'h2);
		// Control and pin enable writes stop without restarting
		for (i = 0; i < 2; i++)
		begin
			xfer(1'b1, 8'h04, 32'h01);
			while (sample_en !== 1'b1) @(posedge hclk);
			xfer(1'b1, i ? 8'h10 : 8'h00, i ? 32'hff : 32'h80);
			repeat (100) @(posedge hclk);
			chk("sampling stopped", 32'h0, {31'h0, sample_en});
			rchk("no done after stop", 8'h04, 32'h01);
		end
		xfer(1'b1, 8'h10, 32'hfe);
		conv(3'h0, 10'h000);
		xfer(1'b1, 8'h10, 32'hff);
		xfer(1'b0, 8'h14, 32'h0);
		xfer(1'b1, 8'h18, 32'h01);
		conv(3'h2, 10'h125);
		chk("irq from status", 32'h1, {31'h0, irq});
		rchk("irq status", 8'h14, 32'h1);
		repeat (2) @(posedge hclk);
		chk("irq after status read", 32'h0, {31'h0, irq});
		xfer(1'b1, 8'h18, 32'h00);
		conv(3'h4, 10'h225);
		chk("masked irq", 32'h0, {31'h0, irq});
		// Left-justified, then eight bits on a halved conversion clock
		xfer(1'b1, 8'h00, 32'hc0);
		xfer(1'b1, 8'h04, 32'h03);
		wait_samp;
		chk("justified window", 32'd28, n);
		do xfer(1'b0, 8'h04, 32'h0); while (rd[7] !== 1'b1);
		rchk("justified high", 8'h08, 32'h69);
		rchk("justified low", 8'h0c, 32'h40);
		xfer(1'b1, 8'h00, 32'ha1);
		xfer(1'b1, 8'h04, 32'h03);
		wait_samp;
		chk("slow window", 32'd56, n);
		do xfer(1'b0, 8'h04, 32'h0); while (rd[7] !== 1'b1);
		rchk("eight bit high", 8'h08, 32'h69);
		rchk("eight bit low", 8'h0c, 32'h00);
		xfer(1'b1, 8'h00, 32'h80);
		// Reset mid-conversion with a request pending
		xfer(1'b1, 8'h18, 32'h01);
		xfer(1'b1, 8'h04, 32'h01);
		wait_samp;
		chk("irq pending", 32'h1, {31'h0, irq});
		do_reset;
		chk("trial code cleared", 32'h0, {22'h0, dac_code});
		chk("irq cancelled", 32'h0, {31'h0, irq});
		rchk("flag cleared", 8'h04, 32'h0);
		rchk("control cleared", 8'h00, 32'h0);
		rchk("mask cleared", 8'h18, 32'h0);
		summarize;
	end
endmodule

`default_nettype wire
